/* dsuca_alarm_bit.v */
// One alarm status bit with latched or following behaviour.
`timescale 1ns/10ps
module dsuca_alarm_bit (
	input  wire pclk,
	input  wire presetn,
	input  wire cond,
	input  wire hold_dis,
	input  wire rd_clear,
	output reg  flag
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
		end else if (hold_dis) begin
			flag <= cond;
		end else if (cond) begin
			flag <= 1'b1;
		end else if (rd_clear) begin
			flag <= 1'b0;
		end
	end
endmodule // dsuca_alarm_bit

/* dsuca_chk_assertions.sv */
// Port-level assertions for the DAC control block.
`timescale 1ns/10ps
module dsuca_chk (
	input wire		pclk,
	input wire		presetn,
	input wire		psel,
	input wire		penable,
	input wire		pwrite,
	input wire [11:0]	paddr,
	input wire [31:0]	prdata,
	input wire		pslverr,
	input wire		clear_pin_a_n,
	input wire		clear_pin_b_n,
	input wire [6:0]	monitor_out_of_range,
	input wire		die_overtemp,
	input wire [143:0]	dac_code,
	input wire		alarm_out,
	input wire		alarm_oe
);
	// Cycles since any clear pin or alarm input was last active.
	reg [3:0]	quiet;
	wire		acc = psel & penable;
	wire		calm = clear_pin_a_n & clear_pin_b_n & ~die_overtemp &
			~|monitor_out_of_range;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			quiet <= 4'h0;
		else if (!calm)
			quiet <= 4'h0;
		else if (quiet != 4'hF)
			quiet <= quiet + 4'h1;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_status_read;
		acc && !pwrite && paddr == 12'h0A0;
	endsequence

	AST_RESET_ZERO: assert property (
		$rose(presetn) |-> dac_code == '0 && !alarm_oe)
		else $error("outputs not cleared by reset");
	AST_PIN_DATA: assert property (
		alarm_oe |-> alarm_out == 1'b0)
		else $error("alarm pin not pulled low");
	AST_READ_LATCH: assert property (
		acc && !pwrite && paddr < 12'h030 && paddr[1:0] == 2'h0 &&
		$stable(dac_code) |->
		prdata == {20'h0, dac_code[paddr[5:2]*12 +: 12]})
		else $error("data read differs from latch");
	AST_WRITE_HOLDS: assert property (
		acc && pwrite && paddr < 12'h030 && quiet > 4'h8 |=>
		$stable(dac_code))
		else $error("data write moved a latch");
	AST_READ_CLEARS: assert property (
		s_status_read ##0 quiet > 4'h8 |=> !alarm_oe)
		else $error("alarm stays after status read");
	AST_ALARM_CAUSE: assert property (
		$rose(alarm_oe) |-> quiet < 4'h6 ||
		$past(acc && pwrite && paddr == 12'h09C))
		else $error("alarm raised without a cause");
	AST_LATCH_CAUSE: assert property (
		$changed(dac_code) && quiet > 4'h8 |->
		$past(acc) || $past(acc, 2) || $past(acc, 3))
		else $error("latch changed without a request");
	AST_UNMAPPED: assert property (
		acc && paddr > 12'h0A4 |-> pslverr && prdata == '0)
		else $error("unmapped access not refused");
endmodule // dsuca_chk

/* dsuca_host.sv */
// Host model issuing APB transfers to the DAC control block.
`timescale 1ns/10ps
module dsuca_host (
	input wire		pclk,
	input wire		pready,
	output reg		psel = 1'b0,
	output reg		penable = 1'b0,
	output reg		pwrite = 1'b0,
	output reg [11:0]	paddr = 12'h000,
	output reg [31:0]	pwdata = 32'h0
);
	task xfer(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data must not look like a held value.
		pwdata <= ~d;
	endtask
endmodule // dsuca_host

/* dsuca_regs.vh */
// Register offsets, field positions and reset values of the DAC control block.
`ifndef DSUCA_REGS_VH
`define DSUCA_REGS_VH
`define DSUCA_NCH          12
`define DSUCA_DW           12
`define DSUCA_NALM         8
`define DSUCA_OFF_DATA0    12'h000
`define DSUCA_OFF_CLRSET0  12'h040
`define DSUCA_OFF_CFG0     12'h080
`define DSUCA_OFF_SYNCSEL  12'h084
`define DSUCA_OFF_PINA     12'h088
`define DSUCA_OFF_PINB     12'h08C
`define DSUCA_OFF_SWCLR    12'h090
`define DSUCA_OFF_ACSRC    12'h094
`define DSUCA_OFF_ACEN     12'h098
`define DSUCA_OFF_ALMCTL   12'h09C
`define DSUCA_OFF_STATUS   12'h0A0
`define DSUCA_OFF_PENDING  12'h0A4
`define DSUCA_BIT_LOAD     0
`define DSUCA_BIT_GALARM   1
`define DSUCA_BIT_OTSRC    2
`define DSUCA_ACEN_LSB     3
`define DSUCA_ACEN_MSB     14
`define DSUCA_BIT_HOLDDIS  8
`define DSUCA_BIT_OT       7
`define DSUCA_DATA_RST     12'h000
`define DSUCA_UNMASK_RST   8'hFF
`endif

/* dsuca_sync2.v */
// Two-flop synchroniser for asynchronous pin levels.
`timescale 1ns/10ps
module dsuca_sync2 #(
	parameter W   = 1,
	parameter RST = 1'b0
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] meta_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= {W{RST}};
			dout     <= {W{RST}};
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule // dsuca_sync2

/* dsuca_top.v */
// DAC synchronous load, clear control and alarm aggregation with APB access.
`timescale 1ns/10ps
`include "dsuca_regs.vh"
// Notes on behaviour
// - Load trigger copies selected data to latches.
// - Data write leaves latch unchanged.
// - Data location reads return latch contents.
// - Only channels written since last trigger reload.
// - Clear entry loads clear setting immediately.
// - Clear exit reloads latch from data register.
// - Low clear pin clears its selected channels.
// - Software clear register clears selected channels.
// - Enabled alarm sources clear enabled channels.
// - Over-temperature input sets its status flag.
// - Over-temp source bit 2, enables bits 14:3.
// - Sensor powered down disables over-temp protection.
// - Out-of-range input sets its alarm bit.
// - Global flag is OR of alarm bits.
// - Latched bits hold until subsided and read.
// - Status read clears bits; persisting ones stay set.
// - Hold disabled: bits follow their condition.
// - Alarm output low while any unmasked alarm bit set.
// - Masked source sets status, not alarm output.
// - Reset sets data and latches to zero.
module dsuca_top (
	input  wire                          pclk,
	input  wire                          presetn,
	input  wire                          psel,
	input  wire                          penable,
	input  wire                          pwrite,
	input  wire [11:0]                   paddr,
	input  wire [31:0]                   pwdata,
	output wire [31:0]                   prdata,
	output wire                          pready,
	output wire                          pslverr,
	input  wire                          clear_pin_a_n,
	input  wire                          clear_pin_b_n,
	input  wire [`DSUCA_NALM-2:0]        monitor_out_of_range,
	input  wire                          die_overtemp,
	input  wire                          local_sensor_powered,
	output wire [`DSUCA_NCH*`DSUCA_DW-1:0] dac_code,
	output wire                          alarm_out,
	output wire                          alarm_oe
);
	localparam NCH = `DSUCA_NCH;
	localparam DW  = `DSUCA_DW;
	localparam NA  = `DSUCA_NALM;
	localparam [11:0] OFF_DATA = `DSUCA_OFF_DATA0;
	localparam [11:0] OFF_CLR  = `DSUCA_OFF_CLRSET0;

	reg  [DW-1:0]  data_reg   [0:NCH-1];
	reg  [DW-1:0]  latch_reg  [0:NCH-1];
	reg  [DW-1:0]  clrset_reg [0:NCH-1];
	reg  [NCH-1:0] sync_load_select_reg;
	reg  [NCH-1:0] pin_a_channel_select_reg;
	reg  [NCH-1:0] pin_b_channel_select_reg;
	reg  [NCH-1:0] software_clear_select_reg;
	reg  [NA-1:0]  auto_clear_source_select_reg;
	reg  [NCH-1:0] auto_clear_channel_enable_reg;
	reg  [NA-1:0]  alarm_source_unmask_reg;
	reg            alarm_hold_disable_reg;
	reg  [NCH-1:0] written_reg;
	reg  [NCH-1:0] clear_prev_reg;
	reg  [31:0]    rdata_reg;
	reg  [31:0]    rdata_next;
	reg  [DW-1:0]  latch_next [0:NCH-1];
	reg  [NCH-1:0] written_next;
	reg            mapped;

	wire           pin_a_n_s;
	wire           pin_b_n_s;
	wire           overtemp_s;
	wire           sensor_on_s;
	wire [NA-2:0]  monitor_s;
	wire [NA-1:0]  alarm_cond;
	wire [NA-1:0]  status;
	wire [NCH-1:0] clear_now;
	wire           global_alarm_flag;
	wire           alarm_active;

	wire acc      = psel & penable;
	wire wr       = acc & pwrite;
	wire rd       = acc & ~pwrite;
	wire in_data  = (paddr[11:6] == OFF_DATA[11:6]);
	wire in_clr   = (paddr[11:6] == OFF_CLR[11:6]);
	wire [3:0] idx = paddr[5:2];
	// Misaligned channel addresses are refused, so they never write a word.
	wire idx_ok   = (idx < NCH) & (paddr[1:0] == 2'b00);
	wire load_trigger_bit = wr & (paddr == `DSUCA_OFF_CFG0) &
		pwdata[`DSUCA_BIT_LOAD];
	wire status_rd = rd & (paddr == `DSUCA_OFF_STATUS);

	// Address decode for the error response; each register is one word.
	always @* begin
		mapped = 1'b0;
		if (in_data | in_clr) begin
			mapped = idx_ok;
		end else begin
			case (paddr)
			`DSUCA_OFF_CFG0,
			`DSUCA_OFF_SYNCSEL,
			`DSUCA_OFF_PINA,
			`DSUCA_OFF_PINB,
			`DSUCA_OFF_SWCLR,
			`DSUCA_OFF_ACSRC,
			`DSUCA_OFF_ACEN,
			`DSUCA_OFF_ALMCTL,
			`DSUCA_OFF_STATUS,
			`DSUCA_OFF_PENDING: mapped = 1'b1;
			default: mapped = 1'b0;
			endcase
		end
	end

	// Clear pins reset to their released level, so no false clear follows.
	dsuca_sync2 #(.W(2), .RST(1'b1)) u_sync_pins (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({clear_pin_a_n, clear_pin_b_n}),
		.dout    ({pin_a_n_s, pin_b_n_s})
	);

	dsuca_sync2 #(.W(NA+1), .RST(1'b0)) u_sync_mon (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({monitor_out_of_range, die_overtemp,
			local_sensor_powered}),
		.dout    ({monitor_s, overtemp_s, sensor_on_s})
	);

	// Bit 7 is the over-temperature flag; it is inert with the sensor off.
	assign alarm_cond = {overtemp_s & sensor_on_s, monitor_s};

	genvar g;
	generate
		for (g = 0; g < NA; g = g + 1) begin : g_alm
			dsuca_alarm_bit u_bit (
				.pclk     (pclk),
				.presetn  (presetn),
				.cond     (alarm_cond[g]),
				.hold_dis (alarm_hold_disable_reg),
				.rd_clear (status_rd),
				.flag     (status[g])
			);
		end
	endgenerate

	assign global_alarm_flag = |status;
	assign alarm_active = |(status & alarm_source_unmask_reg);
	// Open-drain: pulled low while active, released otherwise.
	assign alarm_out = 1'b0;
	assign alarm_oe  = alarm_active;

	// Auto-clear uses the status flags; over-temp source at bit 2.
	// Monitor 2 shares that source bit, so it never auto-clears. A latched
	// over-temperature flag stops clearing once the sensor is powered down.
	wire [NA-1:0] auto_src_hit = {status[`DSUCA_BIT_OT] & sensor_on_s,
		status[NA-2:0]};
	wire [NA-1:0] auto_src_en = {
		auto_clear_source_select_reg[`DSUCA_BIT_OTSRC],
		auto_clear_source_select_reg[NA-2:0] &
		~{{(NA-4){1'b0}}, 1'b1, 2'b00}};
	wire auto_hit = |(auto_src_hit & auto_src_en);

	// Software clear is a level: channels stay cleared until written 0.
	wire [NCH-1:0] clr_by_pin_a = {NCH{~pin_a_n_s}} &
		pin_a_channel_select_reg;
	wire [NCH-1:0] clr_by_pin_b = {NCH{~pin_b_n_s}} &
		pin_b_channel_select_reg;
	wire [NCH-1:0] clr_by_alarm = {NCH{auto_hit}} &
		auto_clear_channel_enable_reg;
	assign clear_now = clr_by_pin_a | clr_by_pin_b |
		software_clear_select_reg | clr_by_alarm;

	// Per-channel latch source. A clear outranks the restore on leaving it,
	// and both outrank a trigger, which only moves pending channels.
	integer j;
	always @* begin
		for (j = 0; j < NCH; j = j + 1) begin
			latch_next[j] = latch_reg[j];
			if (clear_now[j]) begin
				latch_next[j] = clrset_reg[j];
			end else if (clear_prev_reg[j]) begin
				latch_next[j] = data_reg[j];
			end else if (load_trigger_bit & sync_load_select_reg[j] &
				written_reg[j]) begin
				latch_next[j] = data_reg[j];
			end
		end
	end

	// Pending flags: set by a data write, spent by a trigger on the channel.
	integer k;
	always @* begin
		written_next = written_reg;
		for (k = 0; k < NCH; k = k + 1) begin
			// A write in the trigger cycle itself counts for the next one.
			if (wr & in_data & idx_ok & (idx == k))
				written_next[k] = 1'b1;
			else if (load_trigger_bit & sync_load_select_reg[k] &
				~clear_now[k])
				written_next[k] = 1'b0;
		end
	end

	integer i;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < NCH; i = i + 1) begin
				data_reg[i]   <= `DSUCA_DATA_RST;
				latch_reg[i]  <= `DSUCA_DATA_RST;
				clrset_reg[i] <= `DSUCA_DATA_RST;
			end
			sync_load_select_reg          <= {NCH{1'b0}};
			pin_a_channel_select_reg      <= {NCH{1'b0}};
			pin_b_channel_select_reg      <= {NCH{1'b0}};
			software_clear_select_reg     <= {NCH{1'b0}};
			auto_clear_source_select_reg  <= {NA{1'b0}};
			auto_clear_channel_enable_reg <= {NCH{1'b0}};
			alarm_source_unmask_reg       <= `DSUCA_UNMASK_RST;
			alarm_hold_disable_reg        <= 1'b0;
			written_reg                   <= {NCH{1'b0}};
			clear_prev_reg                <= {NCH{1'b0}};
		end else begin
			// The previous clear vector finds channels leaving the clear state.
			clear_prev_reg <= clear_now;
			if (wr) begin
				if (in_data & idx_ok)
					data_reg[idx] <= pwdata[DW-1:0];
				if (in_clr & idx_ok)
					clrset_reg[idx] <= pwdata[DW-1:0];
				case (paddr)
				`DSUCA_OFF_SYNCSEL: sync_load_select_reg <= pwdata[NCH-1:0];
				`DSUCA_OFF_PINA: pin_a_channel_select_reg <= pwdata[NCH-1:0];
				`DSUCA_OFF_PINB: pin_b_channel_select_reg <= pwdata[NCH-1:0];
				`DSUCA_OFF_SWCLR: software_clear_select_reg <= pwdata[NCH-1:0];
				`DSUCA_OFF_ACSRC: auto_clear_source_select_reg <= pwdata[NA-1:0];
				`DSUCA_OFF_ACEN: auto_clear_channel_enable_reg <=
					pwdata[`DSUCA_ACEN_MSB:`DSUCA_ACEN_LSB];
				`DSUCA_OFF_ALMCTL: begin
					alarm_source_unmask_reg <= pwdata[NA-1:0];
					alarm_hold_disable_reg  <= pwdata[`DSUCA_BIT_HOLDDIS];
				end
				default: begin
				end
				endcase
			end
			for (i = 0; i < NCH; i = i + 1)
				latch_reg[i] <= latch_next[i];
			written_reg <= written_next;
		end
	end

	// Data locations return the latch, never the pending input word.
	always @* begin
		rdata_next = 32'h00000000;
		if (in_data & idx_ok)
			rdata_next[DW-1:0] = latch_reg[idx];
		else if (in_clr & idx_ok)
			rdata_next[DW-1:0] = clrset_reg[idx];
		else begin
			case (paddr)
			`DSUCA_OFF_CFG0: rdata_next[`DSUCA_BIT_GALARM] = global_alarm_flag;
			`DSUCA_OFF_SYNCSEL: rdata_next[NCH-1:0] = sync_load_select_reg;
			`DSUCA_OFF_PINA: rdata_next[NCH-1:0] = pin_a_channel_select_reg;
			`DSUCA_OFF_PINB: rdata_next[NCH-1:0] = pin_b_channel_select_reg;
			`DSUCA_OFF_SWCLR: rdata_next[NCH-1:0] = software_clear_select_reg;
			`DSUCA_OFF_ACSRC: rdata_next[NA-1:0] = auto_clear_source_select_reg;
			`DSUCA_OFF_ACEN: rdata_next[`DSUCA_ACEN_MSB:`DSUCA_ACEN_LSB] =
				auto_clear_channel_enable_reg;
			`DSUCA_OFF_ALMCTL: begin
				rdata_next[NA-1:0] = alarm_source_unmask_reg;
				rdata_next[`DSUCA_BIT_HOLDDIS] = alarm_hold_disable_reg;
			end
			`DSUCA_OFF_STATUS: rdata_next[NA-1:0] = status;
			`DSUCA_OFF_PENDING: rdata_next[NCH-1:0] = written_reg;
			default: rdata_next = 32'h00000000;
			endcase
		end
	end

	// Read data is captured in the setup cycle and stands through access.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rdata_reg <= 32'h00000000;
		else if (psel & ~penable & ~pwrite)
			rdata_reg <= rdata_next;
	end

	assign prdata  = rdata_reg;
	// Every access completes in its first access cycle.
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	// Each channel latch drives its slice of the code output directly.
	genvar c;
	generate
		for (c = 0; c < NCH; c = c + 1) begin : g_out
			assign dac_code[c*DW +: DW] = latch_reg[c];
		end
	endgenerate
endmodule // dsuca_top

/* tb.sv */
// Self-checking bench for the DAC control block.
`timescale 1ns/10ps
module tb;
	logic		pclk, presetn;
	logic [10:0]	pv;
	logic [11:0]	dat [12], lat [12], cs [12], wrt, sel, m, cm;
	logic [31:0]	s;
	logic [63:0]	e, q [$];
	wire		psel, penable, pwrite, pready, pslverr, alarm_out, alarm_oe;
	wire [11:0]	paddr;
	wire [31:0]	pwdata, prdata;
	wire [143:0]	dac_code;
	int		n_fail = 0;
	int		comparisons = 0;

	dsuca_host i_host (.pclk(pclk), .pready(pready), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	// Pin vector pv holds pin A, pin B, over-temp, sensor power, monitors.
	dsuca_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clear_pin_a_n(pv[10]), .clear_pin_b_n(pv[9]),
		.monitor_out_of_range(pv[6:0]), .die_overtemp(pv[8]),
		.local_sensor_powered(pv[7]), .dac_code(dac_code),
		.alarm_out(alarm_out), .alarm_oe(alarm_oe));

	function automatic [31:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	task chk(input string n, input [31:0] x, input [31:0] g);
		comparisons++;
		if (g !== x) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask
	task finish_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wr(input [11:0] a, input [31:0] d);
		i_host.xfer(1'b1, a, d);
	endtask
	task rd(input [11:0] a, input [31:0] x, input [31:0] mk = 32'hFFFFFFFF);
		q.push_back({mk, x});
		i_host.xfer(1'b0, a, 32'h0);
	endtask
	task oe(input x);
		#1 chk("alarm_oe", {31'h0, x}, {31'h0, alarm_oe});
	endtask
	task pins(input [10:0] v);
		@(posedge pclk);
		pv <= v;
		repeat (8) @(posedge pclk);
	endtask
	task setclr(input [11:0] nm);
		for (int c = 0; c < 12; c++)
			if (cm[c] && !nm[c])
				lat[c] = dat[c];
		cm = nm;
	endtask
	task chk_all();
		for (int c = 0; c < 12; c++)
			rd(12'(4 * c), {20'h0, cm[c] ? cs[c] : lat[c]});
	endtask

	always @(posedge pclk)
		if (psel && penable && pready && !pwrite && q.size() > 0) begin
			e = q.pop_front();
			chk("prdata", e[31:0], prdata & e[63:32]);
		end
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		finish_test();
	end
	initial begin
		s = 32'h0000C782;
		presetn = 1'b0;
		pv = 11'h680;
		cm = 12'h000;
		wrt = 12'h000;
		for (int c = 0; c < 12; c++) begin
			dat[c] = 12'h000;
			lat[c] = 12'h000;
		end
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk_all();
		repeat (3) begin
			sel = 12'(rnd());
			m = 12'(rnd());
			wr(12'h084, {20'h0, sel});
			for (int c = 0; c < 12; c++)
				if (m[c]) begin
					dat[c] = 12'(rnd());
					wrt[c] = 1'b1;
					wr(12'(4 * c), {20'h0, dat[c]});
				end
			chk_all();
			wr(12'h080, 32'h1);
			for (int c = 0; c < 12; c++)
				if (sel[c] && wrt[c]) begin
					lat[c] = dat[c];
					wrt[c] = 1'b0;
				end
			chk_all();
		end
		// A misaligned data write is refused and sets no pending flag.
		wr(12'h006, 32'h00000FFF);
		rd(12'h0A4, {20'h0, wrt});
		for (int c = 0; c < 12; c++) begin
			cs[c] = 12'(rnd());
			wr(12'h040 + 12'(4 * c), {20'h0, cs[c]});
		end
		m = 12'(rnd());
		wr(12'h088, {20'h0, m});
		wr(12'h08C, {20'h0, ~m});
		pins(11'h280);
		setclr(m);
		chk_all();
		pins(11'h480);
		setclr(~m);
		chk_all();
		pins(11'h680);
		setclr(12'h000);
		chk_all();
		wr(12'h090, {20'h0, m});
		setclr(m);
		chk_all();
		wr(12'h090, 32'h0);
		setclr(12'h000);
		chk_all();
		pins(11'h681);
		oe(1'b1);
		rd(12'h0A0, 32'h1);
		rd(12'h080, 32'h2, 32'h2);
		pins(11'h680);
		rd(12'h0A0, 32'h1);
		oe(1'b0);
		rd(12'h0A0, 32'h0);
		wr(12'h09C, 32'h1FE);
		pins(11'h681);
		oe(1'b0);
		rd(12'h0A0, 32'h1);
		pins(11'h688);
		oe(1'b1);
		pins(11'h680);
		oe(1'b0);
		rd(12'h0A0, 32'h0);
		m = 12'(rnd());
		wr(12'h094, 32'h4);
		wr(12'h098, {17'h0, m, 3'h0});
		pins(11'h700);
		rd(12'h0A0, 32'h0);
		chk_all();
		pins(11'h780);
		setclr(m);
		rd(12'h0A0, 32'h80);
		chk_all();
		pins(11'h680);
		setclr(12'h000);
		chk_all();
		rd(12'h0B0, 32'h0);
		repeat (2) @(posedge pclk);
		finish_test();
	end
endmodule // tb

bind dsuca_top dsuca_chk i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pslverr(pslverr), .clear_pin_a_n(clear_pin_a_n),
	.clear_pin_b_n(clear_pin_b_n),
	.monitor_out_of_range(monitor_out_of_range),
	.die_overtemp(die_overtemp), .dac_code(dac_code),
	.alarm_out(alarm_out), .alarm_oe(alarm_oe));
